// >>> hdl/pll_clock_control_regs.sv
// Register file, interlocks and base clock selector of the loop
//
// How it works
// - Manual mode: enable ignored, enable and flag read 0
// - Lock toggle sets flag; flag and enable interrupt
// - Reading control register clears the change flag
// - Loop stays on while VCO is selected
// - Reset: loop on, select, enable, flag, range clear
// - Output is selected source divided by two
// - Select cannot be set while loop off
// - Output static while switching, three edges each
// - Power-of-two range locked while loop on
// - Range codes 00,01,10 give exponent 0,1,2
// - Mode bit: 1 automatic, 0 manual bandwidth
// - Lock indicator live in automatic, 0 in manual
// - Tracking bit: status in auto, written in manual
// - Manual tracking value kept and restored after auto
// - Multiplier value 0 behaves as 1
// - Multiplier and VCO range locked while loop on
// - Reset loads multiplier 64, VCO range 64
// - Multiplier high register upper nibble reads 0
// - VCO range 0 disables loop, clears select
`timescale 1ns/1ps

module pll_clock_control_regs (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    // Wishbone slave
    input  wire pll_clock_pkg::wb_req_t   wb_i,
    output logic                          wb_ack_o,
    output logic [31:0]                   wb_dat_o,
    // Analog loop status pins
    input  wire logic                     lock_i,
    input  wire logic                     track_i,
    // Source clocks, sampled as data
    input  wire logic                     crystal_clock_i,
    input  wire logic                     vco_clock_i,
    // Outputs to the loop and the system
    output pll_clock_pkg::pll_cfg_t       cfg_o,
    output logic                          base_clock_out_o,
    output logic                          irq_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic xtal_meta_r, xtal_sync_r, xtal_prev_r;
    logic vco_meta_r, vco_sync_r, vco_prev_r;
    logic lock_meta_r, lock_sync_r, lock_prev_r;
    logic track_meta_r, track_sync_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xtal_meta_r  <= 1'b0;
            xtal_sync_r  <= 1'b0;
            xtal_prev_r  <= 1'b0;
            vco_meta_r   <= 1'b0;
            vco_sync_r   <= 1'b0;
            vco_prev_r   <= 1'b0;
            lock_meta_r  <= 1'b0;
            lock_sync_r  <= 1'b0;
            lock_prev_r  <= 1'b0;
            track_meta_r <= 1'b0;
            track_sync_r <= 1'b0;
        end else begin
            xtal_meta_r  <= crystal_clock_i;
            xtal_sync_r  <= xtal_meta_r;
            xtal_prev_r  <= xtal_sync_r;
            vco_meta_r   <= vco_clock_i;
            vco_sync_r   <= vco_meta_r;
            vco_prev_r   <= vco_sync_r;
            lock_meta_r  <= lock_i;
            lock_sync_r  <= lock_meta_r;
            lock_prev_r  <= lock_sync_r;
            track_meta_r <= track_i;
            track_sync_r <= track_meta_r;
        end
    end

    // Sources are sampled at 50 MHz, so each must stay below 25 MHz
    logic xtal_rise, vco_rise;
    assign xtal_rise = xtal_sync_r & ~xtal_prev_r;
    assign vco_rise  = vco_sync_r & ~vco_prev_r;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic        ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic        req, take;

    // Write on low byte lane at given offset, taken on the ack edge
    function automatic logic wr_hit(input pll_clock_pkg::wb_req_t w,
                                    input logic                   t,
                                    input logic [7:0]             ofs);
        wr_hit = t & w.we & w.sel[0] & (w.adr == ofs);
    endfunction : wr_hit

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic        irq_en_r, irq_en_nxt;
    logic        flag_r, flag_nxt;
    logic        loop_on_r, loop_on_nxt;
    logic        bcs_r, bcs_nxt;
    logic [1:0]  pow2_r, pow2_nxt;
    logic        auto_r, auto_nxt;
    logic        track_store_r, track_store_nxt;
    logic [11:0] mult_r, mult_nxt;
    logic [7:0]  vco_range_r, vco_range_nxt;
    logic        irq_r, irq_nxt;
    pll_clock_pkg::pll_cfg_t cfg_r, cfg_nxt;

    logic       lock_toggle, rd_clr, track_read;
    logic [7:0] rd_val, wd;

    assign req         = wb_i.cyc & wb_i.stb;
    assign take        = req & ack_r;
    assign wd          = wb_i.dat[7:0];
    assign lock_toggle = auto_r & (lock_sync_r ^ lock_prev_r);
    assign rd_clr      = ack_nxt & ~wb_i.we
                         & (wb_i.adr == pll_clock_pkg::OFS_CONTROL);
    assign track_read  = auto_r ? track_sync_r : track_store_r;

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_val = 8'h00;
        unique case (wb_i.adr)
            pll_clock_pkg::OFS_CONTROL: begin
                rd_val[pll_clock_pkg::CTL_IRQ_EN_BIT]  = irq_en_r & auto_r;
                rd_val[pll_clock_pkg::CTL_FLAG_BIT]    = flag_r & auto_r;
                rd_val[pll_clock_pkg::CTL_LOOP_ON_BIT] = loop_on_r;
                rd_val[pll_clock_pkg::CTL_BCS_BIT]     = bcs_r;
                rd_val[pll_clock_pkg::CTL_POW2_LSB+:2] = pow2_r;
            end
            pll_clock_pkg::OFS_BANDWIDTH: begin
                rd_val[pll_clock_pkg::BW_AUTO_BIT]  = auto_r;
                rd_val[pll_clock_pkg::BW_LOCK_BIT]  = auto_r & lock_sync_r;
                rd_val[pll_clock_pkg::BW_TRACK_BIT] = track_read;
            end
            pll_clock_pkg::OFS_MULT_HI:
                rd_val = {4'h0, mult_r[11:pll_clock_pkg::MULT_HI_LSB]};
            pll_clock_pkg::OFS_MULT_LO:
                rd_val = mult_r[7:0];
            pll_clock_pkg::OFS_VCO_RANGE:
                rd_val = vco_range_r;
            default:
                rd_val = 8'h00;
        endcase
    end

    // One wait state: ack rises the cycle after the request appears
    always_comb begin
        ack_nxt = req & ~ack_r;
        dat_nxt = dat_r;
        if (ack_nxt) begin
            dat_nxt = {24'h000000, rd_val};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Register writes and interlocks
    // ------------------------------------------------------------------
    always_comb begin
        irq_en_nxt      = irq_en_r;
        flag_nxt        = flag_r;
        loop_on_nxt     = loop_on_r;
        bcs_nxt         = bcs_r;
        pow2_nxt        = pow2_r;
        auto_nxt        = auto_r;
        track_store_nxt = track_store_r;
        mult_nxt        = mult_r;
        vco_range_nxt   = vco_range_r;

        if (wr_hit(wb_i, take, pll_clock_pkg::OFS_CONTROL)) begin
            if (auto_r) begin
                irq_en_nxt = wd[pll_clock_pkg::CTL_IRQ_EN_BIT];
            end
            // Setting needs the loop already on and a live range
            bcs_nxt = wd[pll_clock_pkg::CTL_BCS_BIT]
                      & (bcs_r | (loop_on_r & (|vco_range_r)));
            // Clearing refused while the VCO is selected or being selected
            loop_on_nxt = wd[pll_clock_pkg::CTL_LOOP_ON_BIT] | bcs_r
                          | bcs_nxt;
            if (!loop_on_r) begin
                pow2_nxt = wd[pll_clock_pkg::CTL_POW2_LSB+:2];
            end
        end
        if (wr_hit(wb_i, take, pll_clock_pkg::OFS_BANDWIDTH)) begin
            auto_nxt = wd[pll_clock_pkg::BW_AUTO_BIT];
            // Lock position is test only; writes to it do nothing
            if (!auto_r) begin
                track_store_nxt = wd[pll_clock_pkg::BW_TRACK_BIT];
            end
        end
        if (!loop_on_r) begin
            if (wr_hit(wb_i, take, pll_clock_pkg::OFS_MULT_HI)) begin
                mult_nxt[11:pll_clock_pkg::MULT_HI_LSB] = wd[3:0];
            end
            if (wr_hit(wb_i, take, pll_clock_pkg::OFS_MULT_LO)) begin
                mult_nxt[7:0] = wd;
            end
            if (wr_hit(wb_i, take, pll_clock_pkg::OFS_VCO_RANGE)) begin
                vco_range_nxt = wd;
            end
        end
        if (vco_range_nxt == 8'h00) begin
            bcs_nxt = 1'b0;
        end
        if (!auto_nxt) begin
            irq_en_nxt = 1'b0;
        end

        // Set beats read-clear so a toggle during the read is kept
        if (rd_clr) begin
            flag_nxt = 1'b0;
        end
        if (lock_toggle) begin
            flag_nxt = 1'b1;
        end
        if (!auto_r) begin
            flag_nxt = 1'b0;
        end

        irq_nxt = flag_nxt & irq_en_nxt;

        cfg_nxt.loop_active = loop_on_nxt & (|vco_range_nxt);
        cfg_nxt.auto_mode   = auto_nxt;
        cfg_nxt.track       = auto_nxt ? track_sync_r : track_store_nxt;
        // Code 11 is forbidden to software and passed on unchanged
        cfg_nxt.pow2_exp    = pow2_nxt;
        cfg_nxt.mult        = (mult_nxt == 12'h000) ?
                              pll_clock_pkg::MULT_FLOOR : mult_nxt;
        cfg_nxt.vco_range   = vco_range_nxt;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_r      <= 1'b0;
            flag_r        <= 1'b0;
            loop_on_r     <= pll_clock_pkg::RST_LOOP_ON;
            bcs_r         <= 1'b0;
            pow2_r        <= pll_clock_pkg::RST_POW2;
            auto_r        <= 1'b0;
            track_store_r <= 1'b0;
            mult_r        <= pll_clock_pkg::RST_MULT;
            vco_range_r   <= pll_clock_pkg::RST_VCO_RANGE;
            irq_r         <= 1'b0;
            cfg_r         <= '0;
        end else begin
            irq_en_r      <= irq_en_nxt;
            flag_r        <= flag_nxt;
            loop_on_r     <= loop_on_nxt;
            bcs_r         <= bcs_nxt;
            pow2_r        <= pow2_nxt;
            auto_r        <= auto_nxt;
            track_store_r <= track_store_nxt;
            mult_r        <= mult_nxt;
            vco_range_r   <= vco_range_nxt;
            irq_r         <= irq_nxt;
            cfg_r         <= cfg_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Base clock selector
    // ------------------------------------------------------------------
    pll_clock_pkg::switch_state_t sw_state_r, sw_state_nxt;
    logic       sel_src_r, sel_src_nxt;
    logic [1:0] sw_cnt_r, sw_cnt_nxt;
    logic       clk_out_r, clk_out_nxt;
    logic       old_edge, new_edge;

    assign old_edge = sel_src_r ? vco_rise : xtal_rise;
    assign new_edge = sel_src_r ? xtal_rise : vco_rise;

    always_comb begin
        sw_state_nxt = sw_state_r;
        sel_src_nxt  = sel_src_r;
        sw_cnt_nxt   = sw_cnt_r;
        clk_out_nxt  = clk_out_r;
        unique case (sw_state_r)
            pll_clock_pkg::SW_RUN: begin
                if (bcs_r != sel_src_r) begin
                    sw_state_nxt = pll_clock_pkg::SW_DRAIN;
                    sw_cnt_nxt   = 2'h0;
                end else if (old_edge) begin
                    clk_out_nxt = ~clk_out_r;
                end
            end
            pll_clock_pkg::SW_DRAIN: begin
                if (old_edge) begin
                    sw_cnt_nxt = sw_cnt_r + 2'h1;
                    if (sw_cnt_r == pll_clock_pkg::SWITCH_EDGES - 2'h1) begin
                        sw_state_nxt = pll_clock_pkg::SW_FILL;
                        sw_cnt_nxt   = 2'h0;
                    end
                end
            end
            pll_clock_pkg::SW_FILL: begin
                if (new_edge) begin
                    sw_cnt_nxt = sw_cnt_r + 2'h1;
                    if (sw_cnt_r == pll_clock_pkg::SWITCH_EDGES - 2'h1) begin
                        sw_state_nxt = pll_clock_pkg::SW_RUN;
                        sel_src_nxt  = ~sel_src_r;
                        sw_cnt_nxt   = 2'h0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_state_r <= pll_clock_pkg::SW_RUN;
            sel_src_r  <= 1'b0;
            sw_cnt_r   <= 2'h0;
            clk_out_r  <= 1'b0;
        end else begin
            sw_state_r <= sw_state_nxt;
            sel_src_r  <= sel_src_nxt;
            sw_cnt_r   <= sw_cnt_nxt;
            clk_out_r  <= clk_out_nxt;
        end
    end

    assign wb_ack_o         = ack_r;
    assign wb_dat_o         = dat_r;
    assign cfg_o            = cfg_r;
    assign base_clock_out_o = clk_out_r;
    assign irq_o            = irq_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    irq_en_manual_a: assert property (!auto_r |-> !irq_en_r)
        else $error("lock interrupt enable set in manual mode");
    flag_on_toggle_a: assert property (lock_toggle |=> flag_r)
        else $error("lock toggle did not set change flag");
    irq_from_flag_a: assert property (irq_o == (flag_r & irq_en_r))
        else $error("interrupt output disagrees with flag and enable");
    read_clears_flag_a: assert property (
        rd_clr && !lock_toggle |=> !flag_r)
        else $error("control read did not clear change flag");
    loop_held_on_a: assert property (bcs_r |=> loop_on_r)
        else $error("loop switched off while VCO selected");
    reset_values_a: assert property (
        $past(rst_i) |-> loop_on_r && !bcs_r && !flag_r && pow2_r == 2'h0
                         && mult_r == 12'h040 && vco_range_r == 8'h40)
        else $error("register reset values wrong");
    half_rate_a: assert property (
        sw_state_r == pll_clock_pkg::SW_RUN && bcs_r == sel_src_r
        && old_edge |=> clk_out_r != $past(clk_out_r))
        else $error("output did not toggle on source edge");
    select_needs_loop_a: assert property (
        !loop_on_r && !bcs_r |=> !bcs_r)
        else $error("base clock select set with loop off");
    switch_static_a: assert property (
        sw_state_r != pll_clock_pkg::SW_RUN |=> $stable(clk_out_r))
        else $error("output moved during source switch");
    pow2_locked_a: assert property (loop_on_r |=> $stable(pow2_r))
        else $error("range exponent changed with loop on");
    mult_locked_a: assert property (
        loop_on_r |=> $stable(mult_r) && $stable(vco_range_r))
        else $error("multiplier or VCO range changed with loop on");
    mult_floor_a: assert property (
        !rst_i |=> cfg_o.mult == ((mult_r == 12'h000) ? 12'h001 : mult_r))
        else $error("multiplier zero not treated as one");
    range_zero_a: assert property (
        vco_range_r == 8'h00 |-> !bcs_r && !cfg_o.loop_active)
        else $error("zero VCO range left loop or select active");
    manual_store_a: assert property (auto_r |=> $stable(track_store_r))
        else $error("hidden tracking value changed in auto mode");
    lock_manual_a: assert property (
        ack_nxt && !auto_r && wb_i.adr == pll_clock_pkg::OFS_BANDWIDTH
        |=> !wb_dat_o[pll_clock_pkg::BW_LOCK_BIT])
        else $error("lock read as set in manual mode");

    flag_raised_c: cover property (lock_toggle ##1 flag_r && irq_en_r);
    switch_done_c: cover property (
        sw_state_r == pll_clock_pkg::SW_FILL ##[1:300]
        sw_state_r == pll_clock_pkg::SW_RUN && sel_src_r);
    flag_cleared_c: cover property (flag_r && rd_clr ##1 !flag_r);
    write_refused_c: cover property (
        bcs_r && wr_hit(wb_i, take, pll_clock_pkg::OFS_CONTROL)
        && !wd[pll_clock_pkg::CTL_LOOP_ON_BIT]);

endmodule : pll_clock_control_regs

// >>> hdl/pll_clock_pkg.sv
// Constants, types and register map of the clock control block
package pll_clock_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_BANDWIDTH = 8'h04;
    localparam logic [7:0] OFS_MULT_HI   = 8'h08;
    localparam logic [7:0] OFS_MULT_LO   = 8'h0c;
    localparam logic [7:0] OFS_VCO_RANGE = 8'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_IRQ_EN_BIT  = 7;
    localparam int CTL_FLAG_BIT    = 6;
    localparam int CTL_LOOP_ON_BIT = 5;
    localparam int CTL_BCS_BIT     = 4;
    localparam int CTL_POW2_LSB    = 0;
    localparam int BW_AUTO_BIT     = 7;
    localparam int BW_LOCK_BIT     = 6;
    localparam int BW_TRACK_BIT    = 5;
    localparam int MULT_HI_LSB     = 8;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic        RST_LOOP_ON   = 1'b1;
    localparam logic [1:0]  RST_POW2      = 2'h0;
    localparam logic [11:0] RST_MULT      = 12'h040;
    localparam logic [7:0]  RST_VCO_RANGE = 8'h40;
    localparam logic [11:0] MULT_FLOOR    = 12'h001;
    localparam logic [1:0]  SWITCH_EDGES  = 2'h3;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        loop_active;
        logic        auto_mode;
        logic        track;
        logic [1:0]  pow2_exp;
        logic [11:0] mult;
        logic [7:0]  vco_range;
    } pll_cfg_t;

    typedef enum {SW_RUN, SW_DRAIN, SW_FILL} switch_state_t;

endpackage : pll_clock_pkg

// >>> tb/tb.sv
// Self-checking bench for the loop clock control registers
`timescale 1ns/1ps

module tb;
    // ------------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------------
    logic                    clk_i;
    logic                    rst_i;
    pll_clock_pkg::wb_req_t  wb_i;
    logic                    wb_ack_o;
    logic [31:0]             wb_dat_o;
    logic                    lock_i;
    logic                    track_i;
    logic                    crystal_clock_i;
    logic                    vco_clock_i;
    pll_clock_pkg::pll_cfg_t cfg_o;
    logic                    base_clock_out_o;
    logic                    irq_o;
    int                      failures;
    int                      num_checks;
    int                      cycles;
    int                      xc_cnt;
    logic [31:0]             q;
    int                      n;
    pll_clock_pkg::pll_cfg_t cfg_exp;

    typedef struct packed {
        logic       we;
        logic [7:0] adr;
        logic [7:0] dat;
        logic [7:0] exp;
    } row_t;

    // Reads compare, writes only set up the next read
    row_t rows [27] = '{
        '{1'b0,8'h00,8'h00,8'h20}, '{1'b0,8'h04,8'h00,8'h00},
        '{1'b0,8'h08,8'h00,8'h00}, '{1'b0,8'h0c,8'h00,8'h40},
        '{1'b0,8'h10,8'h00,8'h40}, '{1'b0,8'h14,8'h00,8'h00},
        '{1'b1,8'h0c,8'h12,8'h00}, '{1'b0,8'h0c,8'h00,8'h40},
        '{1'b1,8'h00,8'h21,8'h00}, '{1'b0,8'h00,8'h00,8'h20},
        '{1'b1,8'h00,8'h00,8'h00}, '{1'b1,8'h00,8'h10,8'h00},
        '{1'b0,8'h00,8'h00,8'h00},
        '{1'b1,8'h00,8'h01,8'h00}, '{1'b0,8'h00,8'h00,8'h01},
        '{1'b1,8'h00,8'h02,8'h00}, '{1'b0,8'h00,8'h00,8'h02},
        '{1'b1,8'h00,8'h00,8'h00},
        '{1'b1,8'h08,8'hff,8'h00}, '{1'b0,8'h08,8'h00,8'h0f},
        '{1'b1,8'h0c,8'h00,8'h00}, '{1'b1,8'h08,8'h00,8'h00},
        '{1'b1,8'h04,8'h20,8'h00}, '{1'b0,8'h04,8'h00,8'h20},
        '{1'b1,8'h00,8'h80,8'h00}, '{1'b0,8'h00,8'h00,8'h00},
        '{1'b1,8'h10,8'h00,8'h00}
    };

    pll_clock_control_regs pll_clock_control_regs_inst (
        .clk_i            (clk_i),
        .rst_i            (rst_i),
        .wb_i             (wb_i),
        .wb_ack_o         (wb_ack_o),
        .wb_dat_o         (wb_dat_o),
        .lock_i           (lock_i),
        .track_i          (track_i),
        .crystal_clock_i  (crystal_clock_i),
        .vco_clock_i      (vco_clock_i),
        .cfg_o            (cfg_o),
        .base_clock_out_o (base_clock_out_o),
        .irq_o            (irq_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Crystal period 6 cycles, VCO period 4 cycles, both slow enough
    // for the two-flop sampling in the design
    always @(posedge clk_i) begin
        xc_cnt <= (xc_cnt == 2) ? 0 : xc_cnt + 1;
        if (xc_cnt == 2) crystal_clock_i <= ~crystal_clock_i;
        vco_clock_i <= (cycles % 2 == 1) ? ~vco_clock_i : vco_clock_i;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Request held until ack is sampled high at a rising edge
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [7:0] d, output logic [31:0] rd);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_i <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'h1,
                  dat:{24'h0, d}};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        check("ack", {31'h0, wb_ack_o}, 32'h1);
        rd = wb_dat_o;
        wb_i <= '0;
    endtask : bus

    task automatic wait_edge(output int cnt);
        logic b;
        cnt = 0;
        b = base_clock_out_o;
        do begin
            @(negedge clk_i);
            cnt++;
        end while (base_clock_out_o === b && cnt < 200);
    endtask : wait_edge

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        wb_i = '0;
        lock_i = 1'b0;
        track_i = 1'b0;
        crystal_clock_i = 1'b0;
        vco_clock_i = 1'b0;
        failures = 0;
        num_checks = 0;
        cycles = 0;
        xc_cnt = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].we, rows[i].adr, rows[i].dat, q);
            if (!rows[i].we) check("reg", q, {24'h0, rows[i].exp});
        end
        $display("test register table done");
        // Loop on with zero range: select refused, floor on multiplier
        bus(1'b1, 8'h04, 8'h00, q);
        bus(1'b1, 8'h00, 8'h20, q);
        bus(1'b1, 8'h00, 8'h30, q);
        bus(1'b0, 8'h00, 8'h00, q);
        check("ctl zero range", q, 32'h20);
        check("loop active", {31'h0, cfg_o.loop_active}, 32'h0);
        check("mult floor", {20'h0, cfg_o.mult}, 32'h1);
        $display("test interlocks done");
        // Automatic mode, lock toggle, flag and request
        // Manual tracking value 1 is stored as auto mode starts
        bus(1'b1, 8'h04, 8'ha0, q);
        lock_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        bus(1'b0, 8'h04, 8'h00, q);
        check("bw auto", q, 32'hc0);
        bus(1'b1, 8'h00, 8'ha0, q);
        repeat (2) @(posedge clk_i);
        check("irq set", {31'h0, irq_o}, 32'h1);
        bus(1'b0, 8'h00, 8'h00, q);
        check("ctl flag", q, 32'he0);
        repeat (2) @(posedge clk_i);
        check("irq clear", {31'h0, irq_o}, 32'h0);
        bus(1'b0, 8'h00, 8'h00, q);
        check("flag clear", q, 32'ha0);
        bus(1'b1, 8'h04, 8'h00, q);
        bus(1'b0, 8'h04, 8'h00, q);
        check("track restored", q, 32'h20);
        bus(1'b0, 8'h00, 8'h00, q);
        check("enable forced", q, 32'h20);
        $display("test automatic mode done");
        // Source switch from crystal to VCO
        bus(1'b1, 8'h00, 8'h00, q);
        bus(1'b1, 8'h10, 8'h40, q);
        bus(1'b1, 8'h04, 8'h00, q);
        bus(1'b1, 8'h00, 8'h20, q);
        wait_edge(n);
        wait_edge(n);
        check("crystal half", n, 32'd6);
        // Select alone: loop bit written 0 but must stay on
        bus(1'b1, 8'h00, 8'h10, q);
        bus(1'b0, 8'h00, 8'h00, q);
        check("select set", q, 32'h30);
        repeat (3) @(posedge clk_i);
        wait_edge(n);
        check("frozen", {31'h0, n >= 16}, 32'h1);
        wait_edge(n);
        wait_edge(n);
        check("vco half", n, 32'd4);
        bus(1'b1, 8'h00, 8'h10, q);
        bus(1'b0, 8'h00, 8'h00, q);
        check("loop kept", q, 32'h30);
        $display("test clock select done");
        // Reset in mid-run returns every field to its reset value
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        cfg_exp = '{pll_clock_pkg::RST_LOOP_ON, 1'b0, 1'b0,
                    pll_clock_pkg::RST_POW2, pll_clock_pkg::RST_MULT,
                    pll_clock_pkg::RST_VCO_RANGE};
        check("cfg reset", {7'h0, cfg_o}, {7'h0, cfg_exp});
        check("out reset", {31'h0, base_clock_out_o}, 32'h0);
        bus(1'b0, 8'h00, 8'h00, q);
        check("ctl reset", q, 32'h20);
        bus(1'b0, 8'h04, 8'h00, q);
        check("bw reset", q, 32'h00);
        $display("test reset done");
        final_report();
    end
endmodule : tb
